/* File: hdl/dpmx_defines.svh */
`ifndef DPMX_DEFINES_SVH
`define DPMX_DEFINES_SVH

// widths of the shared pin groups
`define DPMX_ADDR_W      11
`define DPMX_IO_W        8
`define DPMX_SEL_W       5
`define DPMX_PM_W        8
`define DPMX_BANKS       4

// field positions inside the encoded select code
`define DPMX_SEL_LO_MSB  2
`define DPMX_SEL_PAR_LO  3
`define DPMX_SEL_PAR_HI  4

// field positions inside the shared address pins
`define DPMX_ADDR_SEL_LSB 8

// positions inside the edge detector input vector
`define DPMX_EV_MRST     0
`define DPMX_EV_PE      1
`define DPMX_EV_IRQ     2
`define DPMX_EV_PMS     3
`define DPMX_EV_W       4

// reset values and the parity-check enable code
`define DPMX_RST_MODE_IN 1'b0
`define DPMX_RST_ADDR    11'h000
`define DPMX_RST_BYTE    8'h00
`define DPMX_RST_STROBE  4'h0
`define DPMX_PE_EN_ALL   2'h3

`endif

/* File: hdl/dpmx_pkg.sv */
`include "dpmx_defines.svh"

package dpmx_pkg;

   // kind of cycle the sequencer asks for this clock
   typedef enum logic [1:0]
   {
      DPMX_CYC_IDLE,
      DPMX_CYC_ROW,
      DPMX_CYC_COL,
      DPMX_CYC_IO
   } dpmx_cyc_e;

   // one request from the memory sequencer
   typedef struct packed
   {
      dpmx_cyc_e                  cyc;
      logic [`DPMX_ADDR_W-1:0]    addr;
      logic [`DPMX_SEL_W-1:0]     sel;
      logic [`DPMX_IO_W-1:0]      wdata;
      logic                       io_wr;
      logic                       mem_write;
      logic                       par_lo;
      logic                       par_hi;
      logic                       par_drive;
      logic [`DPMX_BANKS-1:0]     ras;
      logic [`DPMX_BANKS-1:0]     cash;
      logic [`DPMX_BANKS-1:0]     casl;
   } dpmx_req_s;

endpackage

/* File: hdl/dpmx_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none

// rising transition finder for synchronous pin levels
module dpmx_edge_detect
#(
   parameter int WIDTH = 4
)
(
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic [WIDTH-1:0] i_level,
   input  wire logic [WIDTH-1:0] i_rst_level,
   output logic      [WIDTH-1:0] o_prev,
   output logic      [WIDTH-1:0] o_rise
);

   if (WIDTH < 1)
   begin : g_chk
      $error("dpmx_edge_detect: WIDTH must be at least one");
   end

   // previous level per bit
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_prev <= '0;
      else
         o_prev <= i_level;
   end

   // low to high per bit; reset-level mask blocks false edges
   genvar g;
   for (g = 0; g < WIDTH; g++)
   begin : g_bit
      assign o_rise[g] = i_level[g] & ~o_prev[g] & ~i_rst_level[g];
   end

endmodule

`default_nettype wire

/* File: hdl/dpmx_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpmx_defines.svh"

module dpmx_top
#(
   parameter int PM_W = `DPMX_PM_W
)
(
   input  wire logic                    i_clk,
   input  wire logic                    i_resetn,
   input  wire dpmx_pkg::dpmx_req_s     i_req,
   input  wire logic                    i_master_reset_in_n,
   input  wire logic [`DPMX_IO_W-1:0]   i_periph_byte_bus,
   input  wire logic                    i_high_col_strobe3,
   input  wire logic                    i_low_col_strobe3,
   input  wire logic                    i_low_col_strobe2,
   input  wire logic [1:0]              i_parity_chk_en,
   input  wire logic                    i_powerdown,
   input  wire logic                    i_refresh_normal,
   input  wire logic                    i_powerdown_refresh_clk,
   input  wire logic                    i_power_mgmt_sample_in,
   input  wire logic [PM_W-1:0]         i_pm_ctrl,
   output logic [`DPMX_ADDR_W-1:0]      o_dram_addr,
   output logic [`DPMX_IO_W-1:0]        o_periph_byte_bus_oe,
   output logic                         o_low_byte_parity,
   output logic                         o_high_byte_parity,
   output logic                         o_parity_oe,
   output logic [`DPMX_BANKS-1:0]       o_row_strobe,
   output logic [`DPMX_BANKS-1:0]       o_high_col_strobe,
   output logic                         o_high_col_strobe3_oe,
   output logic [`DPMX_BANKS-1:0]       o_low_col_strobe,
   output logic [1:0]                   o_low_col_strobe_oe,
   output logic                         o_mem_write_read,
   output logic                         o_refresh,
   output logic                         o_cas_input_mode,
   output logic                         o_parity_error,
   output logic                         o_coproc_irq13,
   output logic [`DPMX_IO_W-1:0]        o_periph_rdata,
   output logic                         o_periph_rvalid,
   output logic [PM_W-1:0]              o_pm_ctrl,
   output logic                         o_pm_valid
);

   if (PM_W < 1)
   begin : g_chk
      $error("dpmx_top: PM_W must be at least one");
   end

   // true when the low address byte carries peripheral write data
   function automatic logic drive_byte(input dpmx_pkg::dpmx_req_s r);
      drive_byte = (r.cyc == dpmx_pkg::DPMX_CYC_IO) && r.io_wr;
   endfunction

   // true for either half of a DRAM access
   function automatic logic dram_cyc(input dpmx_pkg::dpmx_req_s r);
      dram_cyc = (r.cyc == dpmx_pkg::DPMX_CYC_ROW) || (r.cyc == dpmx_pkg::DPMX_CYC_COL);
   endfunction

   logic [`DPMX_EV_W-1:0] ev_level;
   logic [`DPMX_EV_W-1:0] ev_rise;
   logic [`DPMX_EV_W-1:0] ev_mask;
   logic                  input_mode;
   logic                  pe_enabled;
   logic                  mrst_rise;

   // pin levels watched for rising transitions
   assign ev_level[`DPMX_EV_MRST] = i_master_reset_in_n;
   assign ev_level[`DPMX_EV_PE]   = i_low_col_strobe3;
   assign ev_level[`DPMX_EV_IRQ]  = i_low_col_strobe2;
   assign ev_level[`DPMX_EV_PMS]  = i_power_mgmt_sample_in;
   assign ev_mask                 = '0;

   dpmx_edge_detect
   #(
      .WIDTH (`DPMX_EV_W)
   )
   u_edge
   (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_level     (ev_level),
      .i_rst_level (ev_mask),
      .o_prev      (),
      .o_rise      (ev_rise)
   );

   assign mrst_rise  = ev_rise[`DPMX_EV_MRST];
   assign input_mode = o_cas_input_mode;
   assign pe_enabled = input_mode && (i_parity_chk_en == `DPMX_PE_EN_ALL);

   // strap caught as master reset rises, held until the next rise
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_cas_input_mode <= `DPMX_RST_MODE_IN;
      else if (mrst_rise)
         o_cas_input_mode <= ~i_high_col_strobe3;
   end

   // shared address pins: row, column, or select code plus byte bus
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_dram_addr          <= `DPMX_RST_ADDR;
         o_periph_byte_bus_oe <= `DPMX_RST_BYTE;
      end
      else if (dram_cyc(i_req))
      begin
         o_dram_addr          <= i_req.addr;
         o_periph_byte_bus_oe <= '1;
      end
      else if (i_req.cyc == dpmx_pkg::DPMX_CYC_IO)
      begin
         o_dram_addr <= {i_req.sel[`DPMX_SEL_LO_MSB:0], i_req.wdata};
         o_periph_byte_bus_oe <= drive_byte(i_req) ? '1 : '0;
      end
      else
      begin
         o_periph_byte_bus_oe <= '1;
      end
   end

   // parity pins: data parity for DRAM, select bits 3 and 4 for I/O
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_low_byte_parity  <= 1'b0;
         o_high_byte_parity <= 1'b0;
         o_parity_oe        <= 1'b0;
      end
      else if (i_req.cyc == dpmx_pkg::DPMX_CYC_IO)
      begin
         o_low_byte_parity  <= i_req.sel[`DPMX_SEL_PAR_LO];
         o_high_byte_parity <= i_req.sel[`DPMX_SEL_PAR_HI];
         o_parity_oe        <= 1'b1;
      end
      else
      begin
         o_low_byte_parity  <= i_req.par_lo;
         o_high_byte_parity <= i_req.par_hi;
         o_parity_oe        <= dram_cyc(i_req) && i_req.par_drive;
      end
   end

   // peripheral read data taken from the byte bus
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_periph_rdata  <= `DPMX_RST_BYTE;
         o_periph_rvalid <= 1'b0;
      end
      else
      begin
         o_periph_rvalid <= (i_req.cyc == dpmx_pkg::DPMX_CYC_IO) && !i_req.io_wr;
         if ((i_req.cyc == dpmx_pkg::DPMX_CYC_IO) && !i_req.io_wr)
            o_periph_rdata <= i_periph_byte_bus;
      end
   end

   // row and column strobes with strap-dependent pin directions
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_row_strobe          <= `DPMX_RST_STROBE;
         o_high_col_strobe     <= `DPMX_RST_STROBE;
         o_low_col_strobe      <= `DPMX_RST_STROBE;
         o_high_col_strobe3_oe <= 1'b0;
         o_low_col_strobe_oe   <= 2'h0;
      end
      else
      begin
         o_row_strobe      <= i_req.ras;
         o_high_col_strobe <= i_req.cash;
         o_low_col_strobe  <= i_req.casl;
         // strap pin floats while master reset is low
         o_high_col_strobe3_oe <= i_master_reset_in_n && !input_mode;
         o_low_col_strobe_oe   <= (i_master_reset_in_n && !input_mode) ? 2'h3 : 2'h0;
      end
   end

   // parity error and coprocessor interrupt pulses
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_parity_error <= 1'b0;
         o_coproc_irq13 <= 1'b0;
      end
      else
      begin
         o_parity_error <= pe_enabled && ev_rise[`DPMX_EV_PE];
         o_coproc_irq13 <= input_mode && ev_rise[`DPMX_EV_IRQ];
      end
   end

   // memory direction and refresh source
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_mem_write_read <= 1'b0;
         o_refresh        <= 1'b0;
      end
      else
      begin
         o_mem_write_read <= i_req.mem_write;
         o_refresh <= i_powerdown ? i_powerdown_refresh_clk : i_refresh_normal;
      end
   end

   // power-management inputs captured on the sample rise
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pm_ctrl  <= '0;
         o_pm_valid <= 1'b0;
      end
      else
      begin
         o_pm_valid <= ev_rise[`DPMX_EV_PMS];
         if (ev_rise[`DPMX_EV_PMS])
            o_pm_ctrl <= i_pm_ctrl;
      end
   end

   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_mrst_rise;
      !i_master_reset_in_n ##1 i_master_reset_in_n;
   endsequence

   sequence s_pe_rise;
      !i_low_col_strobe3 ##1 i_low_col_strobe3;
   endsequence

   sequence s_irq_rise;
      !i_low_col_strobe2 ##1 i_low_col_strobe2;
   endsequence

   AST_DRAM_ADDR: assert property (dram_cyc(i_req) |=> o_dram_addr == $past(i_req.addr))
      else $error("dram address not driven");

   AST_IO_SEL: assert property ((i_req.cyc == dpmx_pkg::DPMX_CYC_IO) |=>
      o_dram_addr[`DPMX_ADDR_W-1:`DPMX_ADDR_SEL_LSB] ==
      $past(i_req.sel[`DPMX_SEL_LO_MSB:0]))
      else $error("select code low bits wrong");

   AST_PAR_SEL: assert property ((i_req.cyc == dpmx_pkg::DPMX_CYC_IO) |=>
      o_parity_oe && {o_high_byte_parity, o_low_byte_parity} ==
      $past(i_req.sel[`DPMX_SEL_PAR_HI:`DPMX_SEL_PAR_LO]))
      else $error("select bits on parity pins wrong");

   AST_IO_BYTE: assert property ((i_req.cyc == dpmx_pkg::DPMX_CYC_IO) |=>
      (o_periph_byte_bus_oe == ($past(drive_byte(i_req)) ? 8'hff : 8'h00)))
      else $error("byte bus direction wrong");

   AST_STRAP_HI: assert property ((s_mrst_rise ##0 i_high_col_strobe3) |=>
      !o_cas_input_mode ##1 o_high_col_strobe3_oe)
      else $error("output mode not kept");

   AST_STRAP_LO: assert property ((s_mrst_rise ##0 !i_high_col_strobe3) |=>
      o_cas_input_mode ##1 (!o_high_col_strobe3_oe && o_low_col_strobe_oe == 2'h0))
      else $error("input mode not entered");

   AST_MODE_HOLD: assert property (!mrst_rise |=> $stable(o_cas_input_mode))
      else $error("strobe mode changed without master reset");

   AST_PE_GATE: assert property (!pe_enabled |=> !o_parity_error)
      else $error("parity error while disabled");

   AST_PE_EDGE: assert property ((s_pe_rise ##0 pe_enabled) |=> o_parity_error)
      else $error("parity error edge missed");

   // a level held high must never report again
   AST_PE_LEVEL: assert property ((i_low_col_strobe3 && $past(i_low_col_strobe3)) |=>
      !o_parity_error)
      else $error("parity error raised by a held level");

   AST_IRQ13: assert property ((s_irq_rise ##0 input_mode) |=> o_coproc_irq13)
      else $error("coprocessor interrupt missed");

   AST_MEM_DIR: assert property (1'b1 |=> o_mem_write_read == $past(i_req.mem_write))
      else $error("memory direction wrong");

   AST_REFRESH: assert property (i_powerdown |=>
      o_refresh == $past(i_powerdown_refresh_clk))
      else $error("power-down refresh not routed");

   AST_PM_CAP: assert property (ev_rise[`DPMX_EV_PMS] |=>
      o_pm_valid && o_pm_ctrl == $past(i_pm_ctrl))
      else $error("power-management sample lost");

endmodule

`default_nettype wire

/* File: sim/dpmx_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// memory side: byte wires and external select decoder
module dpmx_far_model
(
   input  wire logic [10:0] i_dram_addr,
   input  wire logic [7:0]  i_byte_oe,
   input  wire logic        i_low_byte_parity,
   input  wire logic        i_high_byte_parity,
   input  wire logic        i_parity_oe,
   input  wire logic [7:0]  i_dev_data,
   output logic      [7:0]  o_byte_bus,
   output logic      [31:0] o_chip_select
);
   logic [4:0] code;

   // five-bit code from upper address pins and both parity pins
   assign code = {i_high_byte_parity, i_low_byte_parity, i_dram_addr[10:8]};

   // one of 32 selects, none while parity pins are released
   assign o_chip_select = i_parity_oe ? (32'h1 << code) : 32'h0;

   // peripheral drives each bit the controller leaves undriven
   assign o_byte_bus = (i_byte_oe & i_dram_addr[7:0]) | (~i_byte_oe & i_dev_data);
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpmx_defines.svh"

module tb;
   logic                i_clk = 1'b0;
   logic                i_resetn = 1'b0;
   dpmx_pkg::dpmx_req_s i_req = '0;
   logic                mrst_n = 1'b0;
   logic                strap_drv = 1'b1;
   logic                pe_drv = 1'b0;
   logic                irq_drv = 1'b0;
   logic [1:0]          en = 2'h0;
   logic                pd = 1'b0;
   logic                ref_n = 1'b0;
   logic                powerdown_refresh_clk = 1'b0;
   logic                pms = 1'b0;
   logic [7:0]          pm_ctrl = 8'h00;
   logic [7:0]          pdata = 8'h00;
   logic [7:0]          bus;
   logic [31:0]         cs;
   logic [10:0]         o_dram_addr;
   logic [7:0]          o_byte_oe;
   logic                o_lo_par;
   logic                o_hi_par;
   logic                o_par_oe;
   logic [3:0]          o_row;
   logic [3:0]          o_hi_cas;
   logic                o_strap_oe;
   logic [3:0]          o_lo_cas;
   logic [1:0]          o_lo_oe;
   logic                o_wr;
   logic                o_ref;
   logic                o_mode;
   logic                o_pe;
   logic                o_irq;
   logic [7:0]          o_rdata;
   logic                o_rvalid;
   logic [7:0]          o_pm;
   logic                o_pm_valid;
   int                  err_count = 0;
   int                  total_checks = 0;

   // clock
   always #4 i_clk = ~i_clk;

   dpmx_top dpmx_top_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
      .i_master_reset_in_n(mrst_n), .i_periph_byte_bus(bus),
      .i_high_col_strobe3(o_strap_oe ? o_hi_cas[3] : strap_drv),
      .i_low_col_strobe3(o_lo_oe[1] ? o_lo_cas[3] : pe_drv),
      .i_low_col_strobe2(o_lo_oe[0] ? o_lo_cas[2] : irq_drv),
      .i_parity_chk_en(en), .i_powerdown(pd), .i_refresh_normal(ref_n),
      .i_powerdown_refresh_clk(powerdown_refresh_clk), .i_power_mgmt_sample_in(pms), .i_pm_ctrl(pm_ctrl),
      .o_dram_addr(o_dram_addr), .o_periph_byte_bus_oe(o_byte_oe),
      .o_low_byte_parity(o_lo_par), .o_high_byte_parity(o_hi_par), .o_parity_oe(o_par_oe),
      .o_row_strobe(o_row), .o_high_col_strobe(o_hi_cas), .o_high_col_strobe3_oe(o_strap_oe),
      .o_low_col_strobe(o_lo_cas), .o_low_col_strobe_oe(o_lo_oe), .o_mem_write_read(o_wr),
      .o_refresh(o_ref), .o_cas_input_mode(o_mode), .o_parity_error(o_pe),
      .o_coproc_irq13(o_irq), .o_periph_rdata(o_rdata), .o_periph_rvalid(o_rvalid),
      .o_pm_ctrl(o_pm), .o_pm_valid(o_pm_valid));

   dpmx_far_model dpmx_far_model_inst (.i_dram_addr(o_dram_addr), .i_byte_oe(o_byte_oe),
      .i_low_byte_parity(o_lo_par), .i_high_byte_parity(o_hi_par), .i_parity_oe(o_par_oe),
      .i_dev_data(pdata), .o_byte_bus(bus), .o_chip_select(cs));

   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // strap caught at master reset rise, then held against pin changes
   task automatic set_mode(input logic strap);
      @(negedge i_clk);
      mrst_n = 1'b0;
      strap_drv = strap;
      repeat (3) @(negedge i_clk);
      chk("strap_oe_rst", o_strap_oe, 1'b0);
      chk("low_oe_rst", o_lo_oe, 2'h0);
      mrst_n = 1'b1;
      repeat (3) @(negedge i_clk);
      chk("cas_mode", o_mode, {~strap});
      chk("strap_oe", o_strap_oe, strap);
      chk("low_oe", o_lo_oe, {strap, strap});
      strap_drv = ~strap;
      repeat (6) @(negedge i_clk);
      chk("mode_held", o_mode, {~strap});
   endtask

   function automatic logic ev_out(input int which);
      case (which)
         0: return o_pe;
         1: return o_irq;
         default: return o_pm_valid;
      endcase
   endfunction

   task automatic ev_pin(input int which, input logic v);
      case (which)
         0: pe_drv = v;
         1: irq_drv = v;
         default: pms = v;
      endcase
   endtask

   // pin held high several cycles must give exactly want pulses: one when the output is enabled, none otherwise
   task automatic ev_test(input int which, input logic want);
      int         cnt;
      logic [7:0] pmv;
      cnt = 0;
      pmv = 8'($urandom);
      @(negedge i_clk);
      pm_ctrl = pmv;
      ev_pin(which, 1'b1);
      for (int k = 0; k < 8; k++)
      begin
         @(negedge i_clk);
         if (ev_out(which) === 1'b1)
         begin
            cnt++;
            if (which == 2)
               chk("pm_values", o_pm, pmv);
         end
         if (k == 3)
            ev_pin(which, 1'b0);
      end
      chk("pulse_count", cnt, {31'h0, want});
   endtask

   function automatic dpmx_pkg::dpmx_req_s rand_req(input int i);
      dpmx_pkg::dpmx_req_s r;
      logic [63:0]         t;
      t = {$urandom, $urandom};
      r = t[$bits(r)-1:0];
      r.cyc = dpmx_pkg::dpmx_cyc_e'(2'($urandom_range(3, 0)));
      if (i < 32)
      begin
         r.cyc = dpmx_pkg::DPMX_CYC_IO;
         r.sel = 5'(i);
      end
      return r;
   endfunction

   // outputs one cycle after the request r, rpp the one before it
   task automatic check_req(input dpmx_pkg::dpmx_req_s r, input dpmx_pkg::dpmx_req_s rpp,
                            input logic ref_e, input logic [7:0] pd_p, input logic have_pp);
      chk("row_strobe", o_row, r.ras);
      chk("hi_strobe", o_hi_cas, r.cash);
      chk("lo_strobe", o_lo_cas, r.casl);
      chk("mem_dir", o_wr, r.mem_write);
      chk("refresh", o_ref, ref_e);
      chk("rvalid", o_rvalid, r.cyc == dpmx_pkg::DPMX_CYC_IO && !r.io_wr);
      if (r.cyc == dpmx_pkg::DPMX_CYC_IO)
      begin
         chk("sel_low", o_dram_addr[10:8], r.sel[2:0]);
         chk("par_lo", o_lo_par, r.sel[3]);
         chk("par_hi", o_hi_par, r.sel[4]);
         chk("decode", cs, 32'h1 << r.sel);
         chk("par_oe_io", o_par_oe, 1'b1);
         chk("byte_oe", o_byte_oe, r.io_wr ? 8'hff : 8'h00);
         if (r.io_wr)
            chk("byte_out", o_dram_addr[7:0], r.wdata);
         else if (have_pp && rpp.cyc == dpmx_pkg::DPMX_CYC_IO && !rpp.io_wr)
            chk("byte_in", o_rdata, pd_p);
      end
      else
      begin
         chk("byte_oe", o_byte_oe, 8'hff);
         chk("par_oe", o_par_oe, r.cyc != dpmx_pkg::DPMX_CYC_IDLE && r.par_drive);
         chk("par_bits", {o_hi_par, o_lo_par}, {r.par_hi, r.par_lo});
         if (r.cyc != dpmx_pkg::DPMX_CYC_IDLE)
            chk("dram_addr", o_dram_addr, r.addr);
      end
   endtask

   task automatic traffic(input int n);
      dpmx_pkg::dpmx_req_s rp;
      dpmx_pkg::dpmx_req_s rpp;
      logic [7:0]          pd_p;
      logic                ref_e;
      rp = '0;
      pd_p = 8'h00;
      ref_e = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         @(negedge i_clk);
         if (i > 0)
            check_req(rp, rpp, ref_e, pd_p, i > 1);
         rpp = rp;
         rp = rand_req(i);
         pd_p = 8'($urandom);
         i_req = rp;
         pdata = pd_p;
         {pd, ref_n, powerdown_refresh_clk} = 3'($urandom);
         ref_e = pd ? powerdown_refresh_clk : ref_n;
      end
   endtask

   // hang guard
   initial
   begin
      #80000;
      err_count++;
      $display("timeout");
      end_sim();
   end

   // main sequence: output mode, then input mode
   initial
   begin
      void'($urandom(58));
      repeat (16) @(negedge i_clk);
      i_resetn = 1'b1;
      for (int m = 1; m >= 0; m--)
      begin
         set_mode(m[0]);
         for (int e = 0; e < 4; e++)
         begin
            en = 2'(e);
            ev_test(0, m == 0 && e == 3);
            ev_test(1, m == 0);
            ev_test(2, 1'b1);
         end
         traffic(300);
      end
      end_sim();
   end
endmodule

`default_nettype wire
